// ===== logic/pmwc_top.sv
// power mode selection, halt states and wake-up control
`timescale 1ns/10ps
`include "pmwc_params.svh"
module pmwc_top
    import pmwc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    input  wire logic        fast_tick_i,
    input  wire logic        low_tick_i,
    input  wire logic [1:0]  osc_type_i,
    input  wire logic        wdog_sub_src_i,
    input  wire logic        wdog_cfg_en_i,
    input  wire logic        low_voltage_detector_on_i,
    input  wire logic        wdog_overflow_i,
    input  wire logic [7:0]  port_a_i,
    input  wire logic        irq_req_i,
    input  wire logic        irq_enabled_i,
    input  wire logic        stack_full_i,
    input  wire logic        ext_reset_wake_i,
    output logic             sys_clk_en_o,
    output logic             sys_clk_low_o,
    output logic             fast_osc_en_o,
    output logic             sub_clock_en_o,
    output logic             tbase_clk_en_o,
    output logic             wdog_clk_en_o,
    output logic             wdog_clear_o,
    output logic             cpu_hold_o,
    output logic             pc_sp_reset_o,
    output logic             full_reset_o,
    output logic             irq_service_o
);

    // ************************************************************
    // register storage
    // ************************************************************
    // control bytes as software wrote them, minus the read-only bits
    logic [7:0]  mode_ff;
    logic [7:0]  wdog_ff;
    logic [7:0]  port_a_wake_enable_ff;
    logic        power_down_flag_ff;
    logic        watchdog_expired_flag_ff;
    logic        fast_osc_ready_ff;
    logic        slow_osc_ready_ff;
    logic        slow_active_ff;
    logic        quick_run_ff;
    logic [7:0]  port_a_ff;
    logic        irq_block_ff;
    logic [10:0] fast_cnt_ff;
    logic [1:0]  low_cnt_ff;
    pmwc_state_t state_ff;

    // decoded bus strobes and combinational helpers
    logic       wr_stb;
    logic       rd_stb;
    logic       halt_cmd;
    logic       clrwd_cmd;
    logic       wdog_on;
    logic       want_slow;
    logic       halted;
    logic       pa_fall;
    logic       wake_any;
    logic [7:0] pa_hit;
    logic [10:0] fast_need;

    // a request is taken on its first cycle only; the pending ack blocks a repeat
    // only byte lane 0 carries register data, other lanes are ignored
    assign wr_stb    = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
    assign rd_stb    = cyc_i & stb_i & ~we_i & ~ack_o;
    assign halt_cmd  = wr_stb & (adr_i == `PMWC_ADR_CMD) & dat_i[`PMWC_CMD_HALT];
    assign clrwd_cmd = wr_stb & (adr_i == `PMWC_ADR_CMD) & dat_i[`PMWC_CMD_CLRWD];
    // watchdog runs unless both the option and the control nibble disable it
    assign wdog_on   = wdog_cfg_en_i | (wdog_ff[3:0] != `PMWC_WDOG_OFF);
    assign want_slow = ~mode_ff[`PMWC_MODE_FAST]
                     & (mode_ff[`PMWC_MODE_DIV_LO+2:`PMWC_MODE_DIV_LO+1] == 2'b00);
    // halted means one of the four sleep or idle states, not the wake wait
    assign halted    = (state_ff != PMWC_RUN) & (state_ff != PMWC_WAKE);
    // crystal needs the long settle count, both rc types the short one
    assign fast_need = (osc_type_i == PMWC_OSC_XTAL) ? `PMWC_XTAL_CYC : `PMWC_RC_CYC;

    // per-pin falling edge gated by its own enable
    // trade-off: one sample flop per pin rather than a shared edge detector
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pa
            assign pa_hit[gi] = port_a_wake_enable_ff[gi] & port_a_ff[gi] & ~port_a_i[gi];
        end
    endgenerate
    // wake sources are levels or one-cycle pulses on this clock
    assign pa_fall  = |pa_hit;
    // a request already pending at entry cannot wake the part
    assign wake_any = ext_reset_wake_i | pa_fall | (irq_req_i & ~irq_block_ff)
                    | wdog_overflow_i;

    // ************************************************************
    // wishbone slave: one-cycle ack, reads answer next cycle
    // ************************************************************
    // registered ack one cycle after the request is taken
    // read data is captured with ack and holds until the next read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            if (rd_stb) begin
                case (adr_i)
                    `PMWC_ADR_MODE: dat_o <= {24'h000000, mode_ff[7:4], slow_osc_ready_ff,
                                              fast_osc_ready_ff, mode_ff[1:0]};
                    `PMWC_ADR_WDOG: dat_o <= {24'h000000, wdog_ff};
                    `PMWC_ADR_STAT: dat_o <= {24'h000000, 2'b00, slow_active_ff, state_ff,
                                              power_down_flag_ff, watchdog_expired_flag_ff};
                    `PMWC_ADR_WAKE: dat_o <= {24'h000000, port_a_wake_enable_ff};
                    default:        dat_o <= 32'h0000_0000; // unmapped reads zero
                endcase
            end
        end
    end

    // control registers; writes land only in run or the wake wait, which keeps them frozen asleep
    // read-only ready bits are masked off so software cannot fake them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_ff               <= `PMWC_MODE_RST;
            wdog_ff               <= `PMWC_WDOG_RST;
            port_a_wake_enable_ff <= 8'h00;
        end else if (wr_stb & ~halted) begin
            if (adr_i == `PMWC_ADR_MODE) mode_ff <= dat_i[7:0] & 8'hF3;
            if (adr_i == `PMWC_ADR_WDOG) wdog_ff <= dat_i[7:0];
            if (adr_i == `PMWC_ADR_WAKE) port_a_wake_enable_ff <= dat_i[7:0];
        end
    end

    // ************************************************************
    // halt state machine
    // ************************************************************
    // halt is taken only from run; the target state uses the settings of that edge
    // limitation: a wake event while waiting for the clock is not queued
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= PMWC_RUN;
        end else begin
            case (state_ff)
                PMWC_RUN: begin
                    if (halt_cmd) begin
                        if (mode_ff[`PMWC_MODE_IDLE]) begin
                            state_ff <= wdog_ff[`PMWC_WDOG_KEEP] ? PMWC_IDLEALL
                                                                 : PMWC_IDLESUB;
                        end else begin
                            state_ff <= (wdog_on | low_voltage_detector_on_i)
                                      ? PMWC_SLPSUB : PMWC_DEEP;
                        end
                    end
                end
                PMWC_DEEP, PMWC_SLPSUB, PMWC_IDLESUB, PMWC_IDLEALL: begin
                    if (wake_any) state_ff <= PMWC_WAKE;
                end
                PMWC_WAKE: begin
                    // resume once the clock in use is ready
                    if (slow_active_ff ? slow_osc_ready_ff
                                       : (fast_osc_ready_ff | quick_run_ff)) begin
                        state_ff <= PMWC_RUN;
                    end
                end
                default: state_ff <= PMWC_RUN;
            endcase
        end
    end

    // previous port sample and pending-interrupt latch taken at entry
    // the port sample resets high so no false falling edge follows reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_a_ff    <= 8'hFF;
            irq_block_ff <= 1'b0;
        end else begin
            port_a_ff <= port_a_i;
            if (halt_cmd) irq_block_ff <= irq_req_i;
            else if (~irq_req_i) irq_block_ff <= 1'b0;
        end
    end

    // ************************************************************
    // status flags
    // ************************************************************
    // an external reset wake clears these flags like a full reset
    // halt clear beats a same-cycle overflow, so every entry starts clean
    always_ff @(posedge clk_i) begin
        if (rst_i | (ext_reset_wake_i & halted)) begin
            power_down_flag_ff       <= 1'b0;
            watchdog_expired_flag_ff <= 1'b0;
        end else begin
            if (halt_cmd & (state_ff == PMWC_RUN)) begin
                power_down_flag_ff       <= 1'b1;
                watchdog_expired_flag_ff <= 1'b0;
            end else begin
                if (clrwd_cmd) power_down_flag_ff <= 1'b0;
                if (wdog_overflow_i) watchdog_expired_flag_ff <= 1'b1;
            end
        end
    end

    // ************************************************************
    // clock source and oscillator ready tracking
    // ************************************************************
    // quick run lasts only until the crystal reports ready
    // limitation: quick wake only from sub-clock sleep, where the low rc still runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_active_ff <= 1'b0;
            quick_run_ff   <= 1'b0;
        end else begin
            // slow takes over only once the low oscillator is stable
            if (want_slow & slow_osc_ready_ff) slow_active_ff <= 1'b1;
            else if (~want_slow) slow_active_ff <= 1'b0;
            if (state_ff == PMWC_SLPSUB & wake_any & mode_ff[`PMWC_MODE_QUICK]
                & (osc_type_i == PMWC_OSC_XTAL)) quick_run_ff <= 1'b1;
            else if (fast_osc_ready_ff) quick_run_ff <= 1'b0;
        end
    end

    // settle counters; ready falls while the oscillator is stopped
    // full-clock idle keeps the fast oscillator, so its ready survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_cnt_ff       <= 11'd0;
            fast_osc_ready_ff <= 1'b0;
        end else if ((state_ff == PMWC_DEEP) | (state_ff == PMWC_SLPSUB)
                     | (state_ff == PMWC_IDLESUB) | slow_active_ff) begin
            fast_cnt_ff       <= 11'd0;
            fast_osc_ready_ff <= 1'b0;
        end else if (~fast_osc_ready_ff & fast_tick_i) begin
            fast_cnt_ff <= fast_cnt_ff + 11'd1;
            if (fast_cnt_ff + 11'd1 >= fast_need) fast_osc_ready_ff <= 1'b1;
        end
    end

    // the low rc stops only in deep sleep; elsewhere its ready stays up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_cnt_ff        <= 2'd0;
            slow_osc_ready_ff <= 1'b0;
        end else if (state_ff == PMWC_DEEP) begin
            low_cnt_ff        <= 2'd0;
            slow_osc_ready_ff <= 1'b0;
        end else if (~slow_osc_ready_ff & low_tick_i) begin
            low_cnt_ff <= low_cnt_ff + 2'd1;
            if ({9'd0, low_cnt_ff + 2'd1} >= `PMWC_LOW_CYC) slow_osc_ready_ff <= 1'b1;
        end
    end

    // ************************************************************
    // registered clock gates and wake actions
    // ************************************************************
    // gates follow the state one cycle late, which keeps every output a flop
    // hazard: cpu hold rises a cycle before the system clock gate falls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_clk_en_o   <= 1'b1;
            sys_clk_low_o  <= 1'b0;
            fast_osc_en_o  <= 1'b1;
            sub_clock_en_o <= 1'b1;
            tbase_clk_en_o <= 1'b1;
            wdog_clk_en_o  <= 1'b1;
        end else begin
            sys_clk_en_o   <= ~((state_ff == PMWC_DEEP) | (state_ff == PMWC_SLPSUB)
                                | (state_ff == PMWC_IDLESUB));
            // peripherals on the system clock see the low source too
            sys_clk_low_o  <= slow_active_ff | quick_run_ff;
            fast_osc_en_o  <= ~slow_active_ff & (state_ff != PMWC_DEEP);
            sub_clock_en_o <= (state_ff != PMWC_DEEP);
            tbase_clk_en_o <= (state_ff == PMWC_RUN) | (state_ff == PMWC_WAKE)
                            | (state_ff == PMWC_IDLESUB) | (state_ff == PMWC_IDLEALL);
            // a system-clocked watchdog dies with the system clock in sub-only idle
            case (state_ff)
                PMWC_DEEP:    wdog_clk_en_o <= 1'b0;
                PMWC_SLPSUB:  wdog_clk_en_o <= wdog_on & wdog_sub_src_i;
                PMWC_IDLESUB: wdog_clk_en_o <= wdog_on & wdog_sub_src_i;
                PMWC_IDLEALL: wdog_clk_en_o <= wdog_on;
                default:      wdog_clk_en_o <= wdog_on;
            endcase
        end
    end

    // one-cycle pulses: watchdog clear on halt, reset and interrupt on wake
    // reset wake outranks overflow; interrupt service yields to both
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdog_clear_o  <= 1'b0;
            pc_sp_reset_o <= 1'b0;
            full_reset_o  <= 1'b0;
            irq_service_o <= 1'b0;
            cpu_hold_o    <= 1'b0;
        end else begin
            wdog_clear_o  <= (halt_cmd & (state_ff == PMWC_RUN)) | clrwd_cmd;
            pc_sp_reset_o <= halted & wdog_overflow_i & ~ext_reset_wake_i;
            full_reset_o  <= halted & ext_reset_wake_i;
            // wake by a serviceable interrupt takes the vector, else resume after halt
            irq_service_o <= halted & irq_req_i & ~irq_block_ff & irq_enabled_i
                           & ~stack_full_i & ~ext_reset_wake_i & ~wdog_overflow_i;
            // hold rises with the halt write so no further instruction slips through
            cpu_hold_o    <= (state_ff != PMWC_RUN) | (halt_cmd & ~halted);
        end
    end

endmodule : pmwc_top

// ===== inc/pmwc_params.svh
// constants for the power mode and wake control block
`ifndef PMWC_PARAMS_SVH
`define PMWC_PARAMS_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define PMWC_ADR_MODE      8'h00
`define PMWC_ADR_WDOG      8'h04
`define PMWC_ADR_CMD       8'h08
`define PMWC_ADR_STAT      8'h0C
`define PMWC_ADR_WAKE      8'h10

// ************************************************************
// field positions and reset values
// ************************************************************
`define PMWC_MODE_FAST     0
`define PMWC_MODE_IDLE     1
`define PMWC_MODE_QUICK    4
`define PMWC_MODE_DIV_LO   5
`define PMWC_WDOG_KEEP     7
`define PMWC_MODE_RST      8'h01
`define PMWC_WDOG_RST      8'h7A
`define PMWC_WDOG_OFF      4'hA
`define PMWC_CMD_HALT      0
`define PMWC_CMD_CLRWD     1

// ************************************************************
// timing: oscillator settle counts in source cycles
// ************************************************************
`define PMWC_XTAL_CYC      11'd1024
`define PMWC_RC_CYC        11'd16
`define PMWC_LOW_CYC       11'd2

`endif

// ===== inc/pmwc_pkg.sv
// types for the power mode and wake control block
package pmwc_pkg;
    typedef enum logic [2:0] {
        PMWC_RUN     = 3'b000,
        PMWC_DEEP    = 3'b001,
        PMWC_SLPSUB  = 3'b010,
        PMWC_IDLESUB = 3'b011,
        PMWC_IDLEALL = 3'b100,
        PMWC_WAKE    = 3'b101
    } pmwc_state_t;

    typedef enum logic [1:0] {
        PMWC_OSC_XTAL = 2'b00,
        PMWC_OSC_HRC  = 2'b01,
        PMWC_OSC_ERC  = 2'b10
    } pmwc_osc_t;
endpackage : pmwc_pkg

// ===== testbench/pmwc_top_properties.sv
// assertion checker for the power mode and wake control block
`timescale 1ns/10ps
module pmwc_top_check
    import pmwc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  adr_i,
    input wire logic [31:0] dat_i,
    input wire logic        we_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic        wdog_overflow_i,
    input wire logic        irq_enabled_i,
    input wire logic        stack_full_i,
    input wire logic        ext_reset_wake_i,
    input wire logic        sys_clk_en_o,
    input wire logic        sys_clk_low_o,
    input wire logic        fast_osc_en_o,
    input wire logic        sub_clock_en_o,
    input wire logic        tbase_clk_en_o,
    input wire logic        wdog_clk_en_o,
    input wire logic        cpu_hold_o,
    input wire logic        pc_sp_reset_o,
    input wire logic        full_reset_o,
    input wire logic        irq_service_o
);
    // ********************
    // port checks
    // ********************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // halt command seen at its acknowledge edge
    logic halt_w;
    assign halt_w = ack_o && we_i && adr_i == 8'h08 && dat_i[0];

    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_request: assert property (ack_o |-> cyc_i && stb_i)
        else $error("ack without a bus request");
    a_halt_holds: assert property (halt_w |-> cpu_hold_o)
        else $error("halt did not hold the cpu");
    a_clock_cpu: assert property (!sys_clk_en_o |-> cpu_hold_o)
        else $error("system clock stopped while the cpu runs");
    a_deep_clocks: assert property (!sub_clock_en_o && !sys_clk_en_o |-> !tbase_clk_en_o)
        else $error("time base runs with every clock stopped");
    a_reset_wake: assert property ($rose(ext_reset_wake_i) && cpu_hold_o |-> ##[0:3] full_reset_o)
        else $error("external reset wake gave no full reset");
    a_wdog_wake: assert property (wdog_overflow_i && cpu_hold_o |-> ##[0:3] pc_sp_reset_o)
        else $error("overflow wake gave no pc and sp reset");
    a_irq_serve: assert property (irq_service_o |-> $past(irq_enabled_i) && !$past(stack_full_i))
        else $error("interrupt serviced while not serviceable");
    // a quick wake runs low while the crystal settles, so only a running cpu counts
    a_fast_stop: assert property ($rose(sys_clk_low_o) && !cpu_hold_o |-> ##[0:3] !fast_osc_en_o)
        else $error("fast oscillator kept on in slow mode");
endmodule : pmwc_top_check

bind pmwc_top pmwc_top_check u_pmwc_top_check (.*);

// ===== testbench/test_pmwc_top.sv
// self-checking testbench for the power mode and wake control block
`timescale 1ns/10ps
`include "pmwc_params.svh"
module test_pmwc_top
    import pmwc_pkg::*;
;
    // ********************
    // stimulus and helpers
    // ********************
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [1:0]  osc_type_i = 2'h1;
    logic [7:0]  port_a_i = 8'hFF;
    logic        we_i = 1'h0, cyc_i = 1'h0, stb_i = 1'h0, fast_tick_i = 1'h0;
    logic        low_tick_i = 1'h0, wdog_sub_src_i = 1'h1, wdog_cfg_en_i = 1'h0;
    logic        low_voltage_detector_on_i = 1'h0, wdog_overflow_i = 1'h0;
    logic        irq_req_i = 1'h0, irq_enabled_i = 1'h1, stack_full_i = 1'h0;
    logic        ext_reset_wake_i = 1'h0;
    logic [31:0] dat_o, q, m, seed = 32'hA5314379;
    logic        ack_o, sys_clk_en_o, sys_clk_low_o, fast_osc_en_o, sub_clock_en_o;
    logic        tbase_clk_en_o, wdog_clk_en_o, wdog_clear_o, cpu_hold_o;
    logic        pc_sp_reset_o, full_reset_o, irq_service_o;
    int          error_cnt = 0, comparisons = 0, cyc_cnt = 0, c0, w;
    int          n_clr = 0, n_full = 0, n_psp = 0, n_svc = 0, e_full = 0, e_psp = 0;
    int          n_tck = 0;

    pmwc_top u_pmwc_top (.*);

    // free running clock, 10 ns period
    always #5 clk_i = ~clk_i;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    task automatic conclude();
        if (error_cnt == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask : cmp

    // one classic cycle; held until ack is sampled, released on that edge
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= wr;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'h1);
        cmp("ack wait", 32'h2, 32'(n));
        q = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        we_i <= 1'h0;
    endtask : wb

    // reread until the masked field matches, bounded
    task automatic poll(input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            wb(1'h0, a, 32'h0);
            n++;
        end while ((q & m) !== v && n < 300);
        cmp("polled field", v, q & m);
    endtask : poll

    // random oscillator ticks, pulse counters and the hang limit
    always @(posedge clk_i) begin
        seed <= xs(seed);
        fast_tick_i <= seed[0];
        low_tick_i <= seed[1] & seed[2];
        cyc_cnt <= cyc_cnt + 1;
        n_clr <= n_clr + int'(wdog_clear_o === 1'h1);
        n_full <= n_full + int'(full_reset_o === 1'h1);
        n_psp <= n_psp + int'(pc_sp_reset_o === 1'h1);
        n_svc <= n_svc + int'(irq_service_o === 1'h1);
        n_tck <= n_tck + int'(fast_tick_i === 1'h1);
        if (cyc_cnt == 30000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, `PMWC_ADR_MODE, 32'h0);
        cmp("mode reset", 32'h01, q & 32'hF3);
        wb(1'h0, `PMWC_ADR_WDOG, 32'h0);
        cmp("wdog reset", 32'h7A, q);
        wb(1'h0, `PMWC_ADR_WAKE, 32'h0);
        cmp("wake reset", 32'h0, q);
        wb(1'h0, 8'h14, 32'h0);
        cmp("unmapped", 32'h0, q);
        // every divider code, fast select low then high
        for (int i = 0; i < 16; i++) begin
            c0 = int'(i < 2);
            wb(1'h1, `PMWC_ADR_MODE, {24'h0, 3'(i), 4'h0, 1'(i >> 3)});
            m = 32'h20;
            poll(`PMWC_ADR_STAT, 32'(c0) << 5);
            m = (c0 != 0) ? 32'h08 : 32'h04;
            poll(`PMWC_ADR_MODE, m);
            cmp("low clock", 32'(c0), 32'(sys_clk_low_o));
            cmp("fast osc", 32'(c0 == 0), 32'(fast_osc_en_o));
        end
        // each halt state, left by a different wake cause
        for (int k = 0; k < 4; k++) begin
            port_a_i <= 8'hFF;
            low_voltage_detector_on_i <= (k == 1);
            irq_enabled_i <= seed[9];
            stack_full_i <= seed[10];
            irq_req_i <= (k == 1);
            w = 32'h41 | (32'(k > 1) << 1);
            wb(1'h1, `PMWC_ADR_WDOG, {24'h0, k == 3, 3'h0, (k > 1) ? 4'h5 : 4'hA});
            wb(1'h1, `PMWC_ADR_MODE, 32'(w));
            wb(1'h1, `PMWC_ADR_WAKE, 32'h04);
            c0 = n_clr;
            wb(1'h1, `PMWC_ADR_CMD, 32'h1);
            wb(1'h1, `PMWC_ADR_MODE, 32'h0);
            wb(1'h0, `PMWC_ADR_STAT, 32'h0);
            cmp("state", 32'(k + 1), 32'(q[4:2]));
            cmp("flags", 32'h2, 32'(q[1:0]));
            cmp("halted", 32'h1, 32'(cpu_hold_o));
            cmp("sys clock", 32'(k == 3), 32'(sys_clk_en_o));
            cmp("time base", 32'(k > 1), 32'(tbase_clk_en_o));
            cmp("sub clock", 32'(k > 0), 32'(sub_clock_en_o));
            cmp("wdog clock", 32'(k > 1), 32'(wdog_clk_en_o));
            cmp("wdog clear", 32'h1, 32'(n_clr - c0));
            case (k)
                0: begin
                    port_a_i <= 8'hFE;
                    repeat (10) @(posedge clk_i);
                    cmp("masked pin", 32'h1, 32'(cpu_hold_o));
                    port_a_i <= 8'hFA;
                end
                1: begin
                    repeat (10) @(posedge clk_i);
                    cmp("pending irq", 32'h1, 32'(cpu_hold_o));
                    irq_req_i <= 1'h0;
                    @(posedge clk_i);
                    irq_req_i <= 1'h1;
                    c0 = n_svc + int'(irq_enabled_i && !stack_full_i);
                end
                2: begin
                    wdog_overflow_i <= 1'h1;
                    @(posedge clk_i);
                    wdog_overflow_i <= 1'h0;
                    e_psp++;
                end
                default: begin
                    ext_reset_wake_i <= 1'h1;
                    @(posedge clk_i);
                    ext_reset_wake_i <= 1'h0;
                    e_full++;
                end
            endcase
            for (int n = 0; n < 4000 && cpu_hold_o !== 1'h0; n++) @(posedge clk_i);
            cmp("resumed", 32'h0, 32'(cpu_hold_o));
            repeat (4) @(posedge clk_i);
            cmp("full resets", 32'(e_full), 32'(n_full));
            cmp("pc sp resets", 32'(e_psp), 32'(n_psp));
            if (k == 1) cmp("irq service", 32'(c0), 32'(n_svc));
            if (k < 3) begin
                wb(1'h0, `PMWC_ADR_STAT, 32'h0);
                cmp("after wake", (k == 2) ? 32'h3 : 32'h2, q & 32'h1F);
                wb(1'h0, `PMWC_ADR_MODE, 32'h0);
                cmp("mode kept", 32'(w), q & 32'hF3);
            end
            if (k == 3) begin
                wb(1'h0, `PMWC_ADR_STAT, 32'h0);
                cmp("reset wake flags", 32'h0, q & 32'h1F);
            end
            if (k == 2) begin
                wb(1'h1, `PMWC_ADR_CMD, 32'h2);
                wb(1'h0, `PMWC_ADR_STAT, 32'h0);
                cmp("pdf cleared", 32'h1, q & 32'h3);
            end
        end
        // crystal with quick wake: low source first, crystal after its settle ticks
        osc_type_i <= 2'h0;
        wb(1'h1, `PMWC_ADR_MODE, 32'h51);
        wb(1'h1, `PMWC_ADR_CMD, 32'h1);
        wb(1'h0, `PMWC_ADR_STAT, 32'h0);
        cmp("xtal halt", 32'h2, 32'(q[4:2]));
        c0 = n_tck;
        port_a_i <= 8'hFB;
        for (int n = 0; n < 20 && cpu_hold_o !== 1'h0; n++) @(posedge clk_i);
        cmp("quick run", 32'h3, {30'h0, sys_clk_low_o, fast_osc_en_o});
        for (int n = 0; n < 4000 && sys_clk_low_o !== 1'h0; n++) @(posedge clk_i);
        w = n_tck - c0;
        cmp("xtal settle", 32'h1, 32'(w >= 1024 && w <= 1028));
        wb(1'h0, `PMWC_ADR_MODE, 32'h0);
        cmp("xtal ready", 32'h55, q & 32'hF7);
        conclude();
    end
endmodule : test_pmwc_top
